// ---- verilog/dst_timer.sv ----
// dst_timer: control, command, flag and debug logic of the dual 8-bit split timer, apb slave.
// assumes a zero-wait apb master on clk; debug_halt is synchronous to clk.
//
// Function
// - while disabled, output-value bits drive the waveform outputs directly.
// - split-mode bit makes two 8-bit counters and the split register map.
// - command 0 none, 2 restart, 3 hard reset ignored when enabled, 1 reserved.
// - command field always reads back as zero in set and clear registers.
// - target 0 selects nothing, 3 selects both counters; 1 and 2 reserved.
// - ones written to the clear register clear those control bits only.
// - ones written to the set register set those control bits only.
// - low compare request needs enable bit 4..6 and matching flag.
// - underflow requests need enable bit 1 or 0 with matching flag.
// - low compare flag sets whenever low counter equals that compare value.
// - flags stay set until software writes one; zero writes ignored.
// - high underflow sets flag bit 1.
// - low underflow sets flag bit 0.
// - debug halt stops the timer unless run-in-debug is set.
// - bus write to low counter beats count and reload; hard clear beats the write.
// - bus write to high counter beats count and reload; hard clear beats the write.
// - clock select divides by 1..1024; enable starts and stops.
// - compare enable lets the waveform output override the port pin.
`timescale 1ns/1ps
module dst_timer (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// register bus
	input  wire dst_pkg::dst_apb_req_t apb_req,
	output dst_pkg::dst_apb_rsp_t      apb_rsp,
	// debug
	input  wire logic                  debug_halt,
	// interrupt requests
	output logic [2:0]                 low_compare_request,
	output logic                       high_underflow_request,
	output logic                       low_underflow_request,
	// waveform outputs
	output logic [5:0]                 waveform_out,
	output logic [5:0]                 waveform_override,
	// counter values
	output logic [7:0]                 low_counter,
	output logic [7:0]                 high_counter
);
	import dst_pkg::*;

	dst_state_t st;
	dst_state_t next_st;
	logic [7:0] idx;
	logic       aligned;
	logic       mapped;
	logic       access;
	logic       setup;
	logic       wr;
	logic [7:0] wbyte;
	logic [1:0] cmd_in;
	logic [1:0] tgt_in;
	logic       cmd_write;
	logic       do_restart;
	logic       do_hard;
	logic       halted;
	logic       run;
	logic       tick;
	logic       low_cnt_wr;
	logic       high_cnt_wr;
	logic       low_unf;
	logic       high_unf;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic [7:0] rbyte;

	assign idx     = apb_req.paddr[9:2];
	assign aligned = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr[DST_ADDR_W-1:10] == '0);
	assign setup   = apb_req.psel && !apb_req.penable;
	assign access  = apb_req.psel && apb_req.penable;
	assign wr      = access && apb_req.pwrite && mapped;
	assign wbyte   = apb_req.pwdata[7:0];
	assign cmd_in  = wbyte[DST_CMD_LSB +: 2];
	assign tgt_in  = wbyte[DST_TARGET_LSB +: 2];

	// address decode; outside split mode only the shared control words answer
	always_comb
	begin
		mapped = 1'b0;
		if (aligned)
		begin
			unique case (idx)
				DST_IDX_CLOCK_CONTROL,
				DST_IDX_SPLIT_MODE,
				DST_IDX_DEBUG_RUN:      mapped = 1'b1;
				DST_IDX_COMPARE_ENABLE,
				DST_IDX_OUTPUT_VALUE,
				DST_IDX_COMMAND_CLEAR,
				DST_IDX_COMMAND_SET,
				DST_IDX_INT_ENABLE,
				DST_IDX_INT_FLAGS,
				DST_IDX_LOW_COUNTER,
				DST_IDX_HIGH_COUNTER,
				DST_IDX_LOW_PERIOD,
				DST_IDX_HIGH_PERIOD:    mapped = st.dual_mode;
				default:                mapped = st.dual_mode && (idx >= DST_IDX_LOW_COMPARE) &&
				                                 (idx < DST_IDX_LOW_COMPARE + 8'(2 * DST_CMP_N));
			endcase
		end
	end

	// commands only act with both counters selected; reserved codes do nothing
	assign cmd_write  = wr && ((idx == DST_IDX_COMMAND_SET) || (idx == DST_IDX_COMMAND_CLEAR));
	assign do_restart = cmd_write && (cmd_in == DST_CMD_RESTART) && (tgt_in == DST_TGT_BOTH);
	assign do_hard    = cmd_write && (cmd_in == DST_CMD_RESET) && (tgt_in == DST_TGT_BOTH) &&
	                    !st.enable;

	assign halted      = debug_halt && !st.run_dbg;
	assign run         = st.enable && st.dual_mode && !halted;
	assign tick        = run && ((st.prescale & dst_div_mask(st.clock_divider_select)) == dst_div_mask(st.clock_divider_select));
	assign low_cnt_wr  = wr && (idx == DST_IDX_LOW_COUNTER);
	assign high_cnt_wr = wr && (idx == DST_IDX_HIGH_COUNTER);

	dst_byte_counter u_low (
		.clk        (clk),
		.reset      (reset),
		.tick       (tick),
		.restart    (do_restart),
		.hard_clear (do_hard),
		.write_en   (low_cnt_wr),
		.write_data (wbyte),
		.period     (st.low_period),
		.value      (low_counter),
		.underflow  (low_unf)
	);

	dst_byte_counter u_high (
		.clk        (clk),
		.reset      (reset),
		.tick       (tick),
		.restart    (do_restart),
		.hard_clear (do_hard),
		.write_en   (high_cnt_wr),
		.write_data (wbyte),
		.period     (st.high_period),
		.value      (high_counter),
		.underflow  (high_unf)
	);

	// read mux; command bits are never stored so they read as zero
	always_comb
	begin
		rbyte = 8'h00;
		unique case (idx)
			DST_IDX_CLOCK_CONTROL:  rbyte = {4'h0, st.clock_divider_select, st.enable};
			DST_IDX_COMPARE_ENABLE: rbyte = st.cmp_en;
			DST_IDX_OUTPUT_VALUE:   rbyte = st.out_val;
			DST_IDX_SPLIT_MODE:     rbyte = {7'h00, st.dual_mode};
			DST_IDX_COMMAND_CLEAR,
			DST_IDX_COMMAND_SET:    rbyte = {6'h00, st.target};
			DST_IDX_INT_ENABLE:     rbyte = st.int_en;
			DST_IDX_INT_FLAGS:      rbyte = st.flags;
			DST_IDX_DEBUG_RUN:      rbyte = {7'h00, st.run_dbg};
			DST_IDX_LOW_COUNTER:    rbyte = low_counter;
			DST_IDX_HIGH_COUNTER:   rbyte = high_counter;
			DST_IDX_LOW_PERIOD:     rbyte = st.low_period;
			DST_IDX_HIGH_PERIOD:    rbyte = st.high_period;
			default:
			begin
				for (int n = 0; n < DST_CMP_N; n++)
				begin
					if (idx == DST_IDX_LOW_COMPARE + 8'(n) * DST_CMP_STRIDE)
						rbyte = st.low_cmp[n];
					if (idx == DST_IDX_HIGH_COMPARE + 8'(n) * DST_CMP_STRIDE)
						rbyte = st.high_cmp[n];
				end
			end
		endcase
		if (!mapped)
			rbyte = 8'h00;
	end

	always_comb
	begin
		next_st  = st;
		flag_set = 8'h00;
		flag_clr = 8'h00;
		// register writes
		if (wr)
		begin
			unique case (idx)
				DST_IDX_CLOCK_CONTROL:
				begin
					next_st.enable = wbyte[DST_ENABLE_BIT];
					next_st.clock_divider_select = wbyte[DST_CLOCK_DIVIDER_SELECT_LSB +: 3];
				end
				DST_IDX_COMPARE_ENABLE: next_st.cmp_en    = wbyte & DST_CHAN_MASK;
				DST_IDX_OUTPUT_VALUE:   next_st.out_val   = wbyte & DST_CHAN_MASK;
				DST_IDX_SPLIT_MODE:     next_st.dual_mode = wbyte[0];
				DST_IDX_COMMAND_CLEAR:  next_st.target    = st.target & ~tgt_in;
				DST_IDX_COMMAND_SET:    next_st.target    = st.target | tgt_in;
				DST_IDX_INT_ENABLE:     next_st.int_en    = wbyte & DST_INT_MASK;
				DST_IDX_INT_FLAGS:      flag_clr          = wbyte & DST_INT_MASK;
				DST_IDX_DEBUG_RUN:      next_st.run_dbg   = wbyte[0];
				DST_IDX_LOW_PERIOD:     next_st.low_period  = wbyte;
				DST_IDX_HIGH_PERIOD:    next_st.high_period = wbyte;
				default:
				begin
					for (int n = 0; n < DST_CMP_N; n++)
					begin
						if (idx == DST_IDX_LOW_COMPARE + 8'(n) * DST_CMP_STRIDE)
							next_st.low_cmp[n] = wbyte;
						if (idx == DST_IDX_HIGH_COMPARE + 8'(n) * DST_CMP_STRIDE)
							next_st.high_cmp[n] = wbyte;
					end
				end
			endcase
		end
		// event flags; a set in the same cycle as a clear wins
		for (int n = 0; n < DST_CMP_N; n++)
			flag_set[DST_LOW_CMP_LSB + n] = (low_counter == st.low_cmp[n]);
		flag_set[DST_HIGH_UNDERFLOW_BIT] = high_unf;
		flag_set[DST_LOW_UNDERFLOW_BIT] = low_unf;
		next_st.flags = (st.flags & ~flag_clr) | flag_set;
		// prescaler restarts with the counters so the first period is whole
		if (!run || do_restart)
			next_st.prescale = 10'h000;
		else
			next_st.prescale = st.prescale + 10'h001;
		// waveform value; single-slope compare while enabled
		for (int n = 0; n < DST_CMP_N; n++)
		begin
			if (!st.enable)
			begin
				next_st.wave[n]     = st.out_val[n];
				next_st.wave[n + 3] = st.out_val[DST_HIGH_CH_LSB + n];
			end
			else
			begin
				next_st.wave[n]     = (low_counter <= st.low_cmp[n]);
				next_st.wave[n + 3] = (high_counter <= st.high_cmp[n]);
			end
		end
		// read data caught in the setup phase, held through the access phase
		if (setup)
			next_st.prdata = {24'h00_0000, rbyte};
		// hard reset leaves nothing behind, not even captured read data
		if (do_hard)
			next_st = dst_reset_state();
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			st <= dst_reset_state();
		else
			st <= next_st;
	end

	assign apb_rsp.prdata  = st.prdata;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = access && !mapped;

	assign low_compare_request    = st.int_en[DST_LOW_CMP_LSB +: 3] & st.flags[DST_LOW_CMP_LSB +: 3];
	assign high_underflow_request = st.int_en[DST_HIGH_UNDERFLOW_BIT] & st.flags[DST_HIGH_UNDERFLOW_BIT];
	assign low_underflow_request  = st.int_en[DST_LOW_UNDERFLOW_BIT] & st.flags[DST_LOW_UNDERFLOW_BIT];
	assign waveform_out           = st.wave;
	// split mode only has pwm-style generation, so enable alone selects override
	assign waveform_override      = {st.cmp_en[DST_HIGH_CH_LSB +: 3], st.cmp_en[2:0]};

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	cmd_reads_zero_a: assert property (setup && !apb_req.pwrite && mapped &&
		(idx == DST_IDX_COMMAND_SET || idx == DST_IDX_COMMAND_CLEAR) |=> apb_rsp.prdata[3:2] == 2'b00)
		else $error("command field read back nonzero");
	hard_ignored_a: assert property (cmd_write && cmd_in == DST_CMD_RESET && st.enable |=> st.enable)
		else $error("hard reset acted while enabled");
	set_bits_a: assert property (wr && idx == DST_IDX_COMMAND_SET && !do_hard |=>
		st.target == ($past(st.target) | $past(tgt_in)))
		else $error("set register did not or-in bits");
	clear_bits_a: assert property (wr && idx == DST_IDX_COMMAND_CLEAR && !do_hard |=>
		st.target == ($past(st.target) & ~$past(tgt_in)))
		else $error("clear register did not mask bits");
	cmp_request_a: assert property (low_counter == st.low_cmp[0] && st.int_en[DST_LOW_CMP_LSB] &&
		!do_hard && !(wr && idx == DST_IDX_INT_ENABLE) |=> low_compare_request[0])
		else $error("compare match with enable gave no request");
	unf_gate_a: assert property (!st.int_en[DST_LOW_UNDERFLOW_BIT] && !wr |=> !low_underflow_request)
		else $error("underflow request without enable");
	flag_sticky_a: assert property (st.flags[DST_HIGH_UNDERFLOW_BIT] && !(wr && idx == DST_IDX_INT_FLAGS)
		&& !do_hard |=> st.flags[DST_HIGH_UNDERFLOW_BIT])
		else $error("flag dropped without software clear");
	low_unf_flag_a: assert property (low_unf && !do_hard |=> st.flags[DST_LOW_UNDERFLOW_BIT])
		else $error("low underflow not flagged");
	high_unf_flag_a: assert property (high_unf && !do_hard |=> st.flags[DST_HIGH_UNDERFLOW_BIT])
		else $error("high underflow not flagged");
	debug_stop_a: assert property (halted && !wr |=> $stable(low_counter) && $stable(high_counter))
		else $error("counter moved during debug halt");
	low_wr_prio_a: assert property (low_cnt_wr |=> low_counter == $past(wbyte))
		else $error("low counter write lost");
	high_wr_prio_a: assert property (high_cnt_wr |=> high_counter == $past(wbyte))
		else $error("high counter write lost");
	disabled_wave_a: assert property (!st.enable && !do_hard |=> waveform_out[0] == $past(st.out_val[0]))
		else $error("disabled output not forced");
	restart_load_a: assert property (do_restart |=> low_counter == $past(st.low_period))
		else $error("restart did not reload");

	restart_seen_c: cover property (do_restart);
	hard_seen_c: cover property (do_hard);
	low_unf_c: cover property (low_unf ##1 low_underflow_request);
	cmp_flag_c: cover property (flag_set[DST_LOW_CMP_LSB] && tick);

endmodule // dst_timer

// ---- verilog/dst_pkg.sv ----
// dst_pkg: register indices, field layout, reset values and carriers for the dual byte timer.
// assumes a 32-bit apb master; every register sits in the low byte of one aligned word.
package dst_pkg;

	localparam int unsigned DST_ADDR_W = 12;
	localparam int unsigned DST_CMP_N  = 3;

	// register indices; byte address is four times the index
	localparam logic [7:0] DST_IDX_CLOCK_CONTROL   = 8'h00;
	localparam logic [7:0] DST_IDX_COMPARE_ENABLE  = 8'h01;
	localparam logic [7:0] DST_IDX_OUTPUT_VALUE    = 8'h02;
	localparam logic [7:0] DST_IDX_SPLIT_MODE      = 8'h03;
	localparam logic [7:0] DST_IDX_COMMAND_CLEAR   = 8'h04;
	localparam logic [7:0] DST_IDX_COMMAND_SET     = 8'h05;
	localparam logic [7:0] DST_IDX_INT_ENABLE      = 8'h0a;
	localparam logic [7:0] DST_IDX_INT_FLAGS       = 8'h0b;
	localparam logic [7:0] DST_IDX_DEBUG_RUN       = 8'h0e;
	localparam logic [7:0] DST_IDX_LOW_COUNTER     = 8'h20;
	localparam logic [7:0] DST_IDX_HIGH_COUNTER    = 8'h21;
	localparam logic [7:0] DST_IDX_LOW_PERIOD      = 8'h26;
	localparam logic [7:0] DST_IDX_HIGH_PERIOD     = 8'h27;
	localparam logic [7:0] DST_IDX_LOW_COMPARE     = 8'h28;
	localparam logic [7:0] DST_IDX_HIGH_COMPARE    = 8'h29;
	localparam logic [7:0] DST_CMP_STRIDE          = 8'h02;

	// field positions and masks
	localparam int unsigned DST_ENABLE_BIT    = 0;
	localparam int unsigned DST_CLOCK_DIVIDER_SELECT_LSB    = 1;
	localparam int unsigned DST_CMD_LSB       = 2;
	localparam int unsigned DST_TARGET_LSB    = 0;
	localparam int unsigned DST_LOW_CMP_LSB   = 4;
	localparam int unsigned DST_HIGH_CH_LSB   = 4;
	localparam int unsigned DST_HIGH_UNDERFLOW_BIT      = 1;
	localparam int unsigned DST_LOW_UNDERFLOW_BIT      = 0;
	localparam logic [7:0]  DST_CHAN_MASK     = 8'h77;
	localparam logic [7:0]  DST_INT_MASK      = 8'h73;

	// command and target codes
	localparam logic [1:0] DST_CMD_NONE    = 2'h0;
	localparam logic [1:0] DST_CMD_RESTART = 2'h2;
	localparam logic [1:0] DST_CMD_RESET   = 2'h3;
	localparam logic [1:0] DST_TGT_NONE    = 2'h0;
	localparam logic [1:0] DST_TGT_BOTH    = 2'h3;

	// reset values
	localparam logic [7:0] DST_PERIOD_RESET = 8'hff;
	localparam logic [7:0] DST_BYTE_RESET   = 8'h00;

	typedef struct packed {
		logic                  psel;
		logic                  penable;
		logic                  pwrite;
		logic [DST_ADDR_W-1:0] paddr;
		logic [31:0]           pwdata;
	} dst_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} dst_apb_rsp_t;

	typedef struct packed {
		logic [7:0] value;
	} dst_cnt_state_t;

	typedef struct packed {
		logic                      enable;
		logic [2:0]                clock_divider_select;
		logic [7:0]                cmp_en;
		logic [7:0]                out_val;
		logic                      dual_mode;
		logic [1:0]                target;
		logic [7:0]                int_en;
		logic [7:0]                flags;
		logic                      run_dbg;
		logic [7:0]                low_period;
		logic [7:0]                high_period;
		logic [DST_CMP_N-1:0][7:0] low_cmp;
		logic [DST_CMP_N-1:0][7:0] high_cmp;
		logic [9:0]                prescale;
		logic [5:0]                wave;
		logic [31:0]               prdata;
	} dst_state_t;

	function automatic dst_state_t dst_reset_state();
		dst_state_t s;
		s             = '0;
		s.low_period  = DST_PERIOD_RESET;
		s.high_period = DST_PERIOD_RESET;
		return s;
	endfunction

	// prescaler terminal mask for divide 1,2,4,8,16,64,256,1024
	function automatic logic [9:0] dst_div_mask(input logic [2:0] sel);
		logic [9:0] m;
		m = 10'h000;
		unique case (sel)
			3'h0: m = 10'h000;
			3'h1: m = 10'h001;
			3'h2: m = 10'h003;
			3'h3: m = 10'h007;
			3'h4: m = 10'h00f;
			3'h5: m = 10'h03f;
			3'h6: m = 10'h0ff;
			3'h7: m = 10'h3ff;
		endcase
		return m;
	endfunction

endpackage

// ---- verilog/dst_byte_counter.sv ----
// dst_byte_counter: one 8-bit down counter with reload from its period.
// assumes tick is a one-cycle enable from the parent prescaler.
`timescale 1ns/1ps
module dst_byte_counter (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// control
	input  wire logic       tick,
	input  wire logic       restart,
	input  wire logic       hard_clear,
	input  wire logic       write_en,
	input  wire logic [7:0] write_data,
	input  wire logic [7:0] period,
	// status
	output logic      [7:0] value,
	output logic            underflow
);
	import dst_pkg::*;

	dst_cnt_state_t st;
	dst_cnt_state_t next_st;

	always_comb
	begin
		next_st   = st;
		underflow = 1'b0;
		if (hard_clear)
			next_st.value = DST_BYTE_RESET;
		else if (write_en)
			next_st.value = write_data;
		else if (restart)
			next_st.value = period;
		else if (tick)
		begin
			if (st.value == 8'h00)
			begin
				next_st.value = period;
				underflow     = 1'b1;
			end
			else
				next_st.value = st.value - 8'h01;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			st <= '0;
		else
			st <= next_st;
	end

	assign value = st.value;

endmodule // dst_byte_counter

// ---- tb/testbench.sv ----
// testbench: self-checking bench for the dual byte timer, driven over apb.
// assumes the zero-wait apb slave of dst_timer; debug_halt is driven synchronously.
`timescale 1ns/1ps
module testbench;
	import dst_pkg::*;

	typedef struct packed {
		logic        err;
		logic        rd;
		logic [31:0] data;
	} dst_note_t;

	logic         clk;
	logic         reset;
	dst_apb_req_t apb_req;
	dst_apb_rsp_t apb_rsp;
	logic         debug_halt;
	logic [2:0]   low_compare_request;
	logic         high_underflow_request;
	logic         low_underflow_request;
	logic [5:0]   waveform_out;
	logic [5:0]   waveform_override;
	logic [7:0]   low_counter;
	logic [7:0]   high_counter;
	dst_note_t    notes[$];
	dst_note_t    note;
	int           mismatches;
	int           checks;
	int           seed;
	logic [7:0]   r;
	logic [7:0]   v;
	int           divs[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

	dst_timer i_dut (
		.clk                    (clk),
		.reset                  (reset),
		.apb_req                (apb_req),
		.apb_rsp                (apb_rsp),
		.debug_halt             (debug_halt),
		.low_compare_request    (low_compare_request),
		.high_underflow_request (high_underflow_request),
		.low_underflow_request  (low_underflow_request),
		.waveform_out           (waveform_out),
		.waveform_override      (waveform_override),
		.low_counter            (low_counter),
		.high_counter           (high_counter)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error bus at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_port(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error port at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// the note goes in before the request so the monitor never runs dry
	task automatic xfer(input logic [11:0] addr, input logic wr_n, input logic [7:0] data,
		input logic err, input logic [7:0] exp);
		int n;
		notes.push_back('{err, !wr_n, {24'h00_0000, exp}});
		@(posedge clk);
		apb_req.psel    <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite  <= wr_n;
		apb_req.paddr   <= addr;
		apb_req.pwdata  <= {24'h00_0000, data};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (apb_rsp.pready !== 1'b1 && n < 100);
		// a slave that never answers counts against the run
		if (apb_rsp.pready !== 1'b1)
			mismatches++;
		apb_req.psel    <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] data);
		xfer({2'b00, idx, 2'b00}, 1'b1, data, 1'b0, 8'h00);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		xfer({2'b00, idx, 2'b00}, 1'b0, 8'h00, 1'b0, exp);
	endtask

	// monitor: every completed transfer takes the oldest note
	always @(posedge clk)
	begin
		if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1)
		begin
			if (notes.size() == 0)
				cmp_bus(32'h0000_0000, 32'hffff_ffff);
			else
			begin
				note = notes.pop_front();
				cmp_bus({31'h0000_0000, apb_rsp.pslverr}, {31'h0000_0000, note.err});
				if (note.rd)
					cmp_bus(apb_rsp.prdata, note.data);
			end
		end
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		mismatches++;
		end_sim();
	end

	initial
	begin
		seed = 37075;
		mismatches = 0;
		checks = 0;
		reset = 1'b1;
		apb_req = '0;
		debug_halt = 1'b0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		cmp_port({3'h0, low_compare_request, high_underflow_request, low_underflow_request}, 8'h00);
		rd(DST_IDX_SPLIT_MODE, 8'h00);
		rd(DST_IDX_DEBUG_RUN, 8'h00);
		xfer({2'b00, DST_IDX_INT_FLAGS, 2'b00}, 1'b0, 8'h00, 1'b1, 8'h00);
		wr(DST_IDX_SPLIT_MODE, 8'h01);
		rd(DST_IDX_SPLIT_MODE, 8'h01);
		rd(DST_IDX_COMMAND_CLEAR, 8'h00);
		rd(DST_IDX_COMMAND_SET, 8'h00);
		rd(DST_IDX_INT_ENABLE, 8'h00);
		rd(DST_IDX_LOW_COUNTER, 8'h00);
		rd(DST_IDX_LOW_PERIOD, 8'hff);
		rd(DST_IDX_INT_FLAGS, 8'h70);
		xfer(12'h018, 1'b0, 8'h00, 1'b1, 8'h00);
		xfer(12'h00e, 1'b1, 8'h5a, 1'b1, 8'h00);
		wr(DST_IDX_LOW_COMPARE + DST_CMP_STRIDE, 8'h20);
		wr(DST_IDX_LOW_COMPARE + DST_CMP_STRIDE + DST_CMP_STRIDE, 8'h30);
		r = 8'h40 | (8'($random(seed)) & 8'h3f);
		wr(DST_IDX_LOW_COMPARE, r);
		wr(DST_IDX_INT_FLAGS, 8'h70);
		rd(DST_IDX_INT_FLAGS, 8'h00);
		wr(DST_IDX_LOW_COUNTER, r);
		rd(DST_IDX_INT_FLAGS, 8'h10);
		wr(DST_IDX_LOW_COUNTER, 8'h05);
		wr(DST_IDX_INT_FLAGS, 8'h00);
		rd(DST_IDX_INT_FLAGS, 8'h10);
		wr(DST_IDX_INT_ENABLE, 8'h10);
		@(negedge clk);
		cmp_port({5'h00, low_compare_request}, 8'h01);
		wr(DST_IDX_INT_ENABLE, 8'h60);
		@(negedge clk);
		cmp_port({5'h00, low_compare_request}, 8'h00);
		r = 8'($random(seed)) & DST_CHAN_MASK;
		wr(DST_IDX_OUTPUT_VALUE, r);
		wr(DST_IDX_COMPARE_ENABLE, 8'h32);
		repeat (2) @(negedge clk);
		cmp_port({2'h0, waveform_out}, {2'h0, r[6:4], r[2:0]});
		cmp_port({2'h0, waveform_override}, 8'h1a);
		// a window of whole prescaler periods holds a fixed tick count whatever the phase
		for (int k = 0; k < 8; k++)
		begin
			wr(DST_IDX_CLOCK_CONTROL, 8'(k * 2 + 1));
			wr(DST_IDX_COMMAND_SET, 8'h0b);
			@(negedge clk);
			cmp_port(low_counter, 8'hff);
			repeat (2 * divs[k]) @(negedge clk);
			cmp_port(low_counter, 8'hfd);
			cmp_port(high_counter, 8'hfd);
		end
		wr(DST_IDX_CLOCK_CONTROL, 8'h01);
		wr(DST_IDX_COMMAND_SET, 8'h0b);
		debug_halt <= 1'b1;
		@(negedge clk);
		v = low_counter;
		repeat (4) @(negedge clk);
		cmp_port(low_counter, v);
		wr(DST_IDX_DEBUG_RUN, 8'h01);
		@(negedge clk);
		v = low_counter;
		@(negedge clk);
		cmp_port(low_counter, v - 8'h01);
		@(posedge clk);
		debug_halt <= 1'b0;
		wr(DST_IDX_LOW_COUNTER, 8'h80);
		@(negedge clk);
		cmp_port(low_counter, 8'h80);
		@(negedge clk);
		cmp_port(low_counter, 8'h7f);
		wr(DST_IDX_HIGH_COUNTER, 8'h90);
		@(negedge clk);
		cmp_port(high_counter, 8'h90);
		wr(DST_IDX_LOW_PERIOD, 8'h03);
		wr(DST_IDX_HIGH_PERIOD, 8'h03);
		wr(DST_IDX_INT_FLAGS, 8'h73);
		wr(DST_IDX_INT_ENABLE, 8'h03);
		wr(DST_IDX_COMMAND_SET, 8'h0b);
		for (int k = 0; k < 5; k++)
		begin
			@(negedge clk);
			cmp_port(low_counter, 8'((7 - k) % 4));
		end
		repeat (2) @(negedge clk);
		cmp_port({7'h00, low_underflow_request}, 8'h01);
		cmp_port({7'h00, high_underflow_request}, 8'h01);
		wr(DST_IDX_INT_ENABLE, 8'h01);
		@(negedge clk);
		cmp_port({6'h00, high_underflow_request, low_underflow_request}, 8'h01);
		wr(DST_IDX_COMMAND_SET, 8'h0f);
		rd(DST_IDX_SPLIT_MODE, 8'h01);
		wr(DST_IDX_CLOCK_CONTROL, 8'h00);
		wr(DST_IDX_INT_FLAGS, 8'h01);
		@(negedge clk);
		cmp_port({7'h00, low_underflow_request}, 8'h00);
		v = low_counter;
		wr(DST_IDX_COMMAND_SET, 8'h07);
		wr(DST_IDX_COMMAND_CLEAR, 8'h08);
		@(negedge clk);
		cmp_port(low_counter, v);
		wr(DST_IDX_COMMAND_CLEAR, 8'h03);
		rd(DST_IDX_COMMAND_SET, 8'h00);
		wr(DST_IDX_COMMAND_SET, 8'h02);
		rd(DST_IDX_COMMAND_CLEAR, 8'h02);
		wr(DST_IDX_COMMAND_SET, 8'h01);
		wr(DST_IDX_COMMAND_CLEAR, 8'h02);
		rd(DST_IDX_COMMAND_SET, 8'h01);
		wr(DST_IDX_COMMAND_SET, 8'h0b);
		rd(DST_IDX_COMMAND_SET, 8'h03);
		@(negedge clk);
		cmp_port(low_counter, 8'h03);
		wr(DST_IDX_COMMAND_SET, 8'h0f);
		rd(DST_IDX_SPLIT_MODE, 8'h00);
		wr(DST_IDX_SPLIT_MODE, 8'h01);
		rd(DST_IDX_LOW_PERIOD, 8'hff);
		rd(DST_IDX_OUTPUT_VALUE, 8'h00);
		rd(DST_IDX_COMMAND_SET, 8'h00);
		repeat (2) @(posedge clk);
		end_sim();
	end

endmodule // testbench
